// *** bench/ddcf_rx_model.sv ***
// Purpose: Far-side link receiver model that watches the encoded lanes.
// Assumes: Symbols arrive one per clock per lane, bit 9 first.
// Notes: Only lanes whose serializer is powered up are heard at all.
`timescale 1ns/100ps
module ddcf_rx_model #(
	parameter int LANES = 5
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [LANES-1:0][9:0] lanes,
	input wire logic [LANES-1:0] lane_pd,
	output logic [LANES-1:0][15:0] commas
);
	// A powered-down lane carries no signal, so its symbols are never counted.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			commas <= '0;
		end else begin
			for (int k = 0; k < LANES; k++) begin
				if (!lane_pd[k] && (lanes[k] === 10'h0fa || lanes[k] === 10'h305)) begin
					commas[k] <= commas[k] + 16'h0001;
				end
			end
		end
	end
endmodule: ddcf_rx_model

// *** bench/tb.sv ***
// Purpose: Self-checking bench for the serial output formatter.
// Assumes: Registers answer within a few cycles of the access phase.
// Notes: The sync phase is shortened to four cycles to keep the run brief.
`timescale 1ns/100ps
module tb;
	typedef struct packed {
		logic w;
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] e;
		logic err;
	} ddcf_row_t;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	ddcf_pkg::ddcf_sample_t sample_in = '0;
	logic sample_valid = 1'b0;
	logic [4:0][9:0] lanes;
	logic [4:0] lane_pd_r;
	logic link_clk_en_r;
	logic [1:0] line_rate_r;
	logic [4:0][15:0] commas;
	int fails = 0;
	int tests_run = 0;
	logic [31:0] rd;
	logic er;
	ddcf_row_t rows [9];
	always #12.5 clock = ~clock;
	ddcf_top #(.CGS_CYCLES(5'h04)) i_dut (.clock(clock), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
		.sample_in(sample_in), .sample_valid(sample_valid), .serial_lane_outputs(lanes),
		.lane_pd_r(lane_pd_r), .link_clk_en_r(link_clk_en_r), .line_rate_r(line_rate_r));
	ddcf_rx_model #(.LANES(5)) i_rx (.clock(clock), .sys_rst(sys_rst), .lanes(lanes),
		.lane_pd(lane_pd_r), .commas(commas));
	// A steady ramp of samples keeps the packing path busy throughout.
	always @(posedge clock) begin
		sample_valid <= !sys_rst;
		sample_in <= ddcf_pkg::ddcf_sample_t'(sample_in + 32'h00020005);
	end
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask: chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		// Only the watchdog ends a wait in which pready_r never rises.
		do begin
			@(posedge clock);
		end while (pready_r !== 1'b1);
		rd = prdata_r;
		er = pslverr_r;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask: apb
	task automatic ctrl(input logic [31:0] v);
		apb(1'b1, 12'h808, v);
		repeat (3) @(posedge clock);
	endtask: ctrl
	task automatic close_out;
		$display("Counts: %0d comparisons, %0d mismatches", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask: close_out
	initial begin
		repeat (6000) @(posedge clock);
		fails++;
		$display("MISMATCH watchdog expected done seen hang");
		close_out();
	end
	initial begin
		rows[0] = {1'b0, 12'h800, 32'h0, 32'h00, 1'b0};
		rows[1] = {1'b0, 12'h804, 32'h0, 32'h7c, 1'b0};
		rows[2] = {1'b0, 12'h808, 32'h0, 32'h00, 1'b0};
		rows[3] = {1'b1, 12'h800, 32'h10, 32'h0, 1'b0};
		rows[4] = {1'b0, 12'h800, 32'h0, 32'h10, 1'b0};
		rows[5] = {1'b1, 12'h804, 32'hfc, 32'h0, 1'b0};
		rows[6] = {1'b0, 12'h804, 32'h0, 32'hfc, 1'b0};
		rows[7] = {1'b1, 12'h810, 32'h55, 32'h0, 1'b1};
		rows[8] = {1'b0, 12'h810, 32'h0, 32'h0, 1'b1};
		repeat (8) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		chk("lane_pd reset", 32'h1f, 32'(lane_pd_r));
		chk("clk_en reset", 32'h0, 32'(link_clk_en_r));
		chk("rate reset", 32'h0, 32'(line_rate_r));
		$display("test reset done");
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			chk("pslverr", 32'(rows[i].err), 32'(er));
			if (!rows[i].w) chk("read data", rows[i].e, rd);
		end
		$display("test registers done");
		// Each rate setting is written with the link held off, as software must.
		for (int r = 0; r < 4; r++) begin
			ctrl(32'(r) << 1);
			chk("line rate", 32'({r[0], r[1]}), 32'(line_rate_r));
		end
		ctrl(32'h10);
		ctrl(32'h30);
		apb(1'b0, 12'h808, 32'h0);
		chk("dec refused", 32'h10, rd);
		$display("test rate and decimation done");
		ctrl(32'h11);
		chk("four lanes pd", 32'h10, 32'(lane_pd_r));
		chk("clk_en on", 32'h1, 32'(link_clk_en_r));
		repeat (12) @(posedge clock);
		chk("comma seen", 32'h1, 32'(commas[0] > 16'h4));
		chk("lane4 silent", 32'h0, 32'(commas[4]));
		ctrl(32'h10);
		chk("pd when off", 32'h1f, 32'(lane_pd_r));
		chk("clk_en off", 32'h0, 32'(link_clk_en_r));
		ctrl(32'h03);
		chk("five lanes pd", 32'h00, 32'(lane_pd_r));
		ctrl(32'h02);
		apb(1'b1, 12'h804, 32'h7c);
		$display("test link enable done");
		ctrl(32'hc3);
		repeat (12) @(posedge clock);
		chk("d21.5 lane0", 32'h2aa, 32'(lanes[0]));
		chk("d21.5 lane4", 32'h2aa, 32'(lanes[4]));
		ctrl(32'hc2);
		ctrl(32'h103);
		repeat (12) @(posedge clock);
		chk("k28.5 lane0", 32'h1, 32'(lanes[0] === 10'h0fa || lanes[0] === 10'h305));
		ctrl(32'h102);
		ctrl(32'h83);
		chk("ramp lane0", 32'h274, 32'(lanes[0]));
		chk("ramp lane1", 32'h1d4, 32'(lanes[1]));
		ctrl(32'h82);
		apb(1'b1, 12'h804, 32'hfc);
		apb(1'b1, 12'h808, 32'h43);
		repeat (3) @(posedge clock);
		chk("prbs lane0", 32'h008, 32'(lanes[0]));
		@(posedge clock);
		chk("prbs lane4", 32'h0c2, 32'(lanes[4]));
		$display("test modes done");
		// Reset lands with the link running, so every output must fall back at once.
		sys_rst <= 1'b1;
		@(posedge clock);
		chk("pd in reset", 32'h1f, 32'(lane_pd_r));
		chk("lane in reset", 32'h0, 32'(lanes[0]));
		sys_rst <= 1'b0;
		apb(1'b0, 12'h804, 32'h0);
		chk("link after reset", 32'h7c, rd);
		apb(1'b0, 12'h808, 32'h0);
		chk("ctrl after reset", 32'h0, rd);
		$display("test reset mid-run done");
		close_out();
	end
endmodule: tb

// *** design/ddcf_lane_enc.sv ***
// Purpose: One lane: optional self-synchronous scrambler followed by an 8b10b encoder.
// Assumes: Control characters bypass the scrambler and leave its state alone.
// Notes: Symbol bit 9 is the first bit on the wire (a), bit 0 the last (j).
`timescale 1ns/100ps
module ddcf_lane_enc (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clr,
	input wire logic scr_en,
	input wire logic [7:0] oct_in,
	input wire logic k_in,
	output logic [9:0] sym
);
	logic rd_r;
	logic rd_nxt;
	logic [14:0] scr_r;
	logic [14:0] scr_nxt;
	logic [7:0] dat;

	always_comb begin
		logic [14:0] st;
		logic s;
		s = 1'b0;
		st = scr_r;
		dat = oct_in;
		for (int b = 7; b >= 0; b--) begin
			s = oct_in[b] ^ st[14] ^ st[13];
			st = {st[13:0], s};
			if (scr_en && !k_in) begin
				dat[b] = s; // R9 R19
			end
		end
		scr_nxt = (scr_en && !k_in) ? st : scr_r;
	end

	always_comb begin
		logic [5:0] c6;
		logic [3:0] c4;
		logic [4:0] x;
		logic [2:0] y;
		logic rd1;
		logic unb6;
		logic unb4;
		x = dat[4:0];
		y = dat[7:5];
		c6 = k_in ? ddcf_pkg::K28_6B : ddcf_pkg::T6[x];
		unb6 = ($countones(c6) != 3);
		if (rd_r && (unb6 || (x == 5'h07 && !k_in))) begin
			c6 = ~c6;
		end
		rd1 = unb6 ? ~rd_r : rd_r;
		c4 = ddcf_pkg::T4[y];
		if (y == 3'h7 && !k_in && ((!rd1 && (x == 5'h11 || x == 5'h12 || x == 5'h14))
			|| (rd1 && (x == 5'h0b || x == 5'h0d || x == 5'h0e)))) begin
			c4 = ddcf_pkg::T4_ALT;
		end
		unb4 = ($countones(c4) != 2);
		if (rd1 && (unb4 || y == 3'h3)) begin
			c4 = ~c4;
		end else if (k_in && !rd1 && !unb4 && y != 3'h3) begin
			// Balanced control tails flip with disparity so the comma keeps its shape.
			c4 = ~c4; // R7
		end
		rd_nxt = unb4 ? ~rd1 : rd1;
		sym = {c6, c4}; // R7
	end

	// The link being off clears disparity and scrambler so every start is identical.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rd_r <= 1'b0;
			scr_r <= ddcf_pkg::SCR_SEED;
		end else if (clr) begin
			rd_r <= 1'b0; // R14
			scr_r <= ddcf_pkg::SCR_SEED;
		end else begin
			rd_r <= rd_nxt;
			scr_r <= scr_nxt;
		end
	end

	scr_hold_a: assert property (@(posedge clock) disable iff (sys_rst) // R9
		!scr_en && !clr |=> $stable(scr_r))
		else $error("scrambler state moved while scrambling is off");
endmodule: ddcf_lane_enc

// *** design/ddcf_top.sv ***
// Purpose: Packs decimated complex samples and sends them over up to five 8b10b lanes.
// Assumes: Samples arrive on clock from the down-converter; serializers sit outside.
// Notes: Registers are reached over APB; answers come one cycle into the access phase.
// Contract
// (R1) Samples are 15-bit I, 15-bit Q, two flags.
// (R2) Pack into 16-bit words, flag in bit 0.
// (R3) Decimation only 4, 8, 10, 16, 20, 32.
// (R4) Gain boost bit doubles final filter output.
// (R5) Software should boost gain when tuned near zero.
// (R6) At most five serial lanes.
// (R7) Spread octets over lanes, encode 8b10b.
// (R8) Lane rate 1, 1.25, 2 or 2.5 times.
// (R9) Scrambler off after reset, enabled by bit.
// (R10) Software writes frames per multiframe minus one.
// (R11) Software keeps frame count within legal range.
// (R12) Rate select bit picks one or two times.
// (R13) Software disables link before changing parameters.
// (R14) Link off holds logic reset, serializers down.
// (R15) Link off also gates link clocks.
// (R16) Selectable link test modes exist.
// (R17) Pseudo-random patterns bypass the 8b10b encoder.
// (R18) Unused lanes are the highest-numbered ones.
// (R19) Scrambler uses the standard self-synchronous polynomial.
// (R20) Flags belong to the same sample instant.
//
// Our own choice: the APB slave port.
`timescale 1ns/100ps
module ddcf_top #(
	parameter int LANES = ddcf_pkg::LANES,
	parameter logic [4:0] CGS_CYCLES = 5'h10
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ddcf_pkg::AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_r,
	output logic pready_r,
	output logic pslverr_r,
	input wire ddcf_pkg::ddcf_sample_t sample_in,
	input wire logic sample_valid,
	output logic [LANES-1:0][9:0] serial_lane_outputs,
	output logic [LANES-1:0] lane_pd_r,
	output logic link_clk_en_r,
	output logic [1:0] line_rate_r
);
	typedef enum logic [1:0] {ST_OFF, ST_CGS, ST_DATA} ddcf_state_t;
	localparam int CTRL_W = $bits(ddcf_pkg::ddcf_ctrl_t);

	logic [7:0] gain_r;
	ddcf_pkg::ddcf_link_t link_r;
	ddcf_pkg::ddcf_ctrl_t ctrl_r;
	ddcf_pkg::ddcf_ctrl_t ctrl_nxt;
	logic [9:0] idx;
	logic setup;
	logic hit;
	logic wr_en;
	logic [31:0] rd_data;
	ddcf_state_t state_r;
	logic [4:0] cgs_cnt_r;
	logic [4:0] mf_cnt_r;
	logic [2:0] lanes;
	logic [2:0] lanes_r;
	logic link_en;
	logic [5:0] dec_fac;
	logic [5:0] dec_cnt_r;
	logic take;
	logic [31:0] word_nxt;
	logic [31:0] word_r;
	logic pend_r;
	logic [31:0] tx_word_r;
	logic tx_ok_r;
	logic [2:0] pos_r;
	logic frame_end;
	logic [7:0] ramp_r;
	logic [6:0] prbs_r;
	logic [6:0] prbs_nxt;
	logic [9:0] prbs_bits;
	logic [LANES-1:0][7:0] lane_oct;
	logic [LANES-1:0] lane_k;
	logic [LANES-1:0][9:0] enc_sym;

	assign idx = paddr[ddcf_pkg::AW-1:2];
	assign setup = psel && !penable;
	assign hit = idx inside {ddcf_pkg::IDX_GAIN, ddcf_pkg::IDX_LINK,
		ddcf_pkg::IDX_CTRL, ddcf_pkg::IDX_STAT};
	assign wr_en = psel && penable && pready_r && pwrite;
	assign link_en = ctrl_r.en;
	assign lanes = ddcf_pkg::lane_count(ctrl_r.dec, ctrl_r.ddr, ctrl_r.p54);
	assign dec_fac = ddcf_pkg::DEC_TAB[ctrl_r.dec];

	always_comb begin
		case (idx)
			ddcf_pkg::IDX_GAIN: rd_data = {24'h000000, gain_r};
			ddcf_pkg::IDX_LINK: rd_data = {24'h000000, link_r};
			ddcf_pkg::IDX_CTRL: rd_data = {23'h000000, ctrl_r};
			ddcf_pkg::IDX_STAT: rd_data = {17'h00000, mf_cnt_r, lanes_r, line_rate_r,
				state_r, pend_r, tx_ok_r, link_clk_en_r};
			default: rd_data = 32'h00000000;
		endcase
	end

	// Every transfer answers at the first access edge; unmapped indices raise pslverr.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h00000000;
		end else begin
			pready_r <= setup;
			pslverr_r <= setup && !hit;
			if (setup && !pwrite) begin
				prdata_r <= rd_data;
			end
		end
	end

	always_comb begin
		ctrl_nxt = ddcf_pkg::ddcf_ctrl_t'(pwdata[CTRL_W-1:0]);
		if (ctrl_nxt.dec >= ddcf_pkg::DEC_CODES) begin
			ctrl_nxt.dec = ctrl_r.dec; // R3
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			gain_r <= ddcf_pkg::GAIN_RST;
			link_r <= ddcf_pkg::LINK_RST; // R9
			ctrl_r <= ddcf_pkg::CTRL_RST;
		end else if (wr_en) begin
			case (idx)
				ddcf_pkg::IDX_GAIN: gain_r <= pwdata[7:0];
				ddcf_pkg::IDX_LINK: link_r <= ddcf_pkg::ddcf_link_t'(pwdata[7:0]);
				ddcf_pkg::IDX_CTRL: ctrl_r <= ctrl_nxt;
				default: ;
			endcase
		end
	end

	function automatic logic [14:0] boost(logic [14:0] v, logic on);
		if (!on) begin
			boost = v;
		end else if (v[14] != v[13]) begin
			boost = v[14] ? ddcf_pkg::SAT_NEG : ddcf_pkg::SAT_POS;
		end else begin
			boost = {v[13:0], 1'b0};
		end
	endfunction: boost

	// One sample in dec_fac is kept; the count restarts if the factor shrinks under it.
	assign take = sample_valid && (dec_cnt_r >= dec_fac - 6'h01); // R3
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			dec_cnt_r <= 6'h00;
		end else if (take) begin
			dec_cnt_r <= 6'h00;
		end else if (sample_valid) begin
			dec_cnt_r <= dec_cnt_r + 6'h01;
		end
	end

	always_comb begin
		word_nxt = {boost(sample_in.i, gain_r[ddcf_pkg::GAIN_BOOST_BIT]), // R1 R4
			sample_in.overrange_flag_first, // R2 R20
			boost(sample_in.q, gain_r[ddcf_pkg::GAIN_BOOST_BIT]),
			sample_in.overrange_flag_second};
	end

	assign frame_end = (state_r == ST_DATA) && ({1'b0, pos_r} + {1'b0, lanes_r}
		>= {1'b0, ddcf_pkg::FRAME_OCTETS});

	// A new word wins over the frame boundary that would consume the old one.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			word_r <= 32'h00000000;
			pend_r <= 1'b0;
		end else if (take) begin
			word_r <= word_nxt;
			pend_r <= 1'b1;
		end else if (frame_end) begin
			pend_r <= 1'b0;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= ST_OFF;
			cgs_cnt_r <= 5'h00;
		end else begin
			case (state_r)
				ST_OFF: if (link_en) begin
					state_r <= ST_CGS;
					cgs_cnt_r <= 5'h00;
				end
				ST_CGS: if (!link_en) begin
					state_r <= ST_OFF; // R14
				end else if (cgs_cnt_r == CGS_CYCLES - 5'h01) begin
					state_r <= ST_DATA;
				end else begin
					cgs_cnt_r <= cgs_cnt_r + 5'h01;
				end
				ST_DATA: if (!link_en) begin
					state_r <= ST_OFF; // R14
				end
				default: state_r <= ST_OFF;
			endcase
		end
	end

	// Octet position within the held frame word; frames count modulo the multiframe size.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pos_r <= 3'h0;
			tx_word_r <= 32'h00000000;
			tx_ok_r <= 1'b0;
			mf_cnt_r <= 5'h00;
		end else if (state_r != ST_DATA) begin
			pos_r <= 3'h0;
			tx_ok_r <= 1'b0;
			mf_cnt_r <= 5'h00;
		end else if (frame_end) begin
			pos_r <= 3'h0;
			tx_word_r <= word_r; // R7
			tx_ok_r <= pend_r;
			mf_cnt_r <= (mf_cnt_r >= link_r.km1) ? 5'h00 : mf_cnt_r + 5'h01;
		end else begin
			pos_r <= pos_r + lanes_r;
		end
	end

	always_comb begin
		logic [6:0] p;
		p = prbs_r;
		for (int b = 9; b >= 0; b--) begin
			prbs_bits[b] = p[6] ^ p[5];
			p = {p[5:0], prbs_bits[b]};
		end
		prbs_nxt = p;
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			prbs_r <= ddcf_pkg::PRBS_SEED;
			ramp_r <= 8'h00;
		end else if (state_r == ST_OFF) begin
			prbs_r <= ddcf_pkg::PRBS_SEED;
			ramp_r <= 8'h00;
		end else begin
			prbs_r <= prbs_nxt;
			ramp_r <= ramp_r + 8'h01;
		end
	end

	// Lanes past the active count carry idle K characters unless the ramp, D21.5 or PRBS7 test mode is set, and are powered down anyway.
	always_comb begin
		logic [3:0] o;
		o = 4'h0;
		for (int k = 0; k < LANES; k++) begin
			o = {1'b0, pos_r} + 4'(k);
			lane_oct[k] = ddcf_pkg::K28_5;
			lane_k[k] = 1'b1;
			if (state_r == ST_DATA && k < int'(lanes_r) && o < 4'(ddcf_pkg::FRAME_OCTETS)
				&& tx_ok_r) begin
				lane_oct[k] = tx_word_r[8 * (3 - int'(o[1:0])) +: 8]; // R7 R18
				lane_k[k] = 1'b0;
			end
			case (ctrl_r.test) // R16
				ddcf_pkg::TM_RAMP: begin
					lane_oct[k] = ramp_r + 8'(k);
					lane_k[k] = 1'b0;
				end
				ddcf_pkg::TM_D21_5: begin
					lane_oct[k] = ddcf_pkg::D21_5;
					lane_k[k] = 1'b0;
				end
				ddcf_pkg::TM_K28_5: begin
					lane_oct[k] = ddcf_pkg::K28_5;
					lane_k[k] = 1'b1;
				end
				default: ;
			endcase
		end
	end

	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane // R6
			ddcf_lane_enc u_enc (
				.clock(clock),
				.sys_rst(sys_rst),
				.clr(state_r == ST_OFF),
				.scr_en(link_r.scrambler_enable),
				.oct_in(lane_oct[g]),
				.k_in(lane_k[g]),
				.sym(enc_sym[g])
			);
		end
	endgenerate

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			serial_lane_outputs <= '0;
		end else begin
			for (int k = 0; k < LANES; k++) begin
				if (state_r == ST_OFF) begin
					serial_lane_outputs[k] <= 10'h000; // R14
				end else if (ctrl_r.test == ddcf_pkg::TM_PRBS7) begin
					serial_lane_outputs[k] <= prbs_bits; // R17
				end else begin
					serial_lane_outputs[k] <= enc_sym[k];
				end
			end
		end
	end

	// Serializer power and clock gate follow the link enable; rate select follows the ddr and p54 bits.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			lane_pd_r <= '1;
			link_clk_en_r <= 1'b0;
			line_rate_r <= 2'h0;
			lanes_r <= 3'h1;
		end else begin
			link_clk_en_r <= link_en; // R15
			line_rate_r <= {ctrl_r.ddr, ctrl_r.p54}; // R8 R12
			lanes_r <= lanes;
			for (int k = 0; k < LANES; k++) begin
				lane_pd_r[k] <= !link_en || (k >= int'(lanes)); // R14 R18
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	sequence en_rise;
		!link_en ##1 link_en;
	endsequence
	// Holds for sync phases of at least four cycles; a dropped enable excuses the next cycle.
	sequence cgs_run;
		(state_r == ST_CGS || !$past(link_en))[*3];
	endsequence

	link_start_a: assert property (en_rise |=> (state_r == ST_CGS) ##1 cgs_run) // R14
		else $error("link did not enter character sync after enable");
	link_off_a: assert property (!link_en |=> lane_pd_r == '1 && !link_clk_en_r) // R14 R15
		else $error("serializers not down with link disabled");
	lane_top_a: assert property (link_en |=> lane_pd_r[0] == 1'b0 // R18
		&& lane_pd_r[LANES-1] == ($past(lanes) < 3'h5))
		else $error("wrong lanes disabled");
	rate_sel_a: assert property (##1 line_rate_r == $past({ctrl_r.ddr, ctrl_r.p54})) // R8 R12
		else $error("line rate select mismatch");
	pack_word_a: assert property (take && !gain_r[ddcf_pkg::GAIN_BOOST_BIT] |=> // R2 R20
		word_r == {$past(sample_in.i), $past(sample_in.overrange_flag_first),
		$past(sample_in.q), $past(sample_in.overrange_flag_second)})
		else $error("packed word does not match sample");
	gain_dbl_a: assert property (take && gain_r[ddcf_pkg::GAIN_BOOST_BIT] // R4
		&& sample_in.i[14:13] == 2'b00 |=> word_r[31:17] == {$past(sample_in.i[13:0]), 1'b0})
		else $error("gain boost did not double the sample");
	dec_span_a: assert property (take |=> (!take)[*3]) // R3
		else $error("decimator kept two samples too close");
	prbs_raw_a: assert property (state_r != ST_OFF && ctrl_r.test == ddcf_pkg::TM_PRBS7 // R17
		|=> serial_lane_outputs[0] == $past(prbs_bits))
		else $error("prbs lane not raw pattern");
	cgs_k_a: assert property (state_r == ST_CGS && ctrl_r.test == ddcf_pkg::TM_NORMAL |=> // R7
		serial_lane_outputs[0] == 10'h0fa || serial_lane_outputs[0] == 10'h305)
		else $error("sync phase did not send comma");
endmodule: ddcf_top

// *** include/ddcf_pkg.sv ***
// Purpose: Shared constants and types for the down-converter serial output formatter.
// Assumes: Registers sit on a 32-bit APB bus, one aligned word per register index.
// Notes: Byte address of a register is four times its index.
package ddcf_pkg;
	localparam int LANES = 5;
	localparam int AW = 12;
	localparam logic [9:0] IDX_GAIN = 10'h200;
	localparam logic [9:0] IDX_LINK = 10'h201;
	localparam logic [9:0] IDX_CTRL = 10'h202;
	localparam logic [9:0] IDX_STAT = 10'h203;
	localparam int GAIN_BOOST_BIT = 4;
	localparam logic [7:0] GAIN_RST = 8'h00;
	localparam logic [7:0] LINK_RST = 8'h7c;
	localparam logic [8:0] CTRL_RST = 9'h000;
	localparam logic [2:0] FRAME_OCTETS = 3'h4;
	localparam logic [7:0] K28_5 = 8'hbc;
	localparam logic [7:0] D21_5 = 8'hb5;
	localparam logic [5:0] K28_6B = 6'h0f;
	localparam logic [6:0] PRBS_SEED = 7'h7f;
	localparam logic [14:0] SCR_SEED = 15'h7fff;
	localparam logic [14:0] SAT_POS = 15'h3fff;
	localparam logic [14:0] SAT_NEG = 15'h4000;
	localparam logic [2:0] DEC_CODES = 3'h6;
	localparam logic [5:0] DEC_TAB [6] = '{6'h04, 6'h08, 6'h0a, 6'h10, 6'h14, 6'h20};
	localparam logic [5:0] T6 [32] = '{6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17, 6'h1b, 6'h23, 6'h13, 6'h32,
		6'h0b, 6'h2a, 6'h1a, 6'h3a, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
	localparam logic [3:0] T4 [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
	localparam logic [3:0] T4_ALT = 4'h7;
	typedef enum logic [2:0] {TM_NORMAL, TM_PRBS7, TM_RAMP, TM_D21_5, TM_K28_5} ddcf_test_t;
	typedef struct packed {
		ddcf_test_t test;
		logic [2:0] dec;
		logic p54;
		logic ddr;
		logic en;
	} ddcf_ctrl_t;
	typedef struct packed {
		logic scrambler_enable;
		logic [4:0] km1;
		logic [1:0] rsvd;
	} ddcf_link_t;
	typedef struct packed {
		logic [14:0] i;
		logic [14:0] q;
		logic overrange_flag_first;
		logic overrange_flag_second;
	} ddcf_sample_t;
	function automatic logic [2:0] lane_count(logic [2:0] dc, logic ddr, logic p54);
		case ({dc, ddr, p54})
			5'h02: lane_count = 3'h5;
			5'h03: lane_count = 3'h4;
			5'h04: lane_count = 3'h5;
			5'h05: lane_count = 3'h4;
			5'h06: lane_count = 3'h3;
			5'h07: lane_count = 3'h2;
			5'h08: lane_count = 3'h4;
			5'h0a: lane_count = 3'h2;
			5'h0c: lane_count = 3'h3;
			5'h0d: lane_count = 3'h2;
			5'h0e: lane_count = 3'h2;
			default: lane_count = 3'h1;
		endcase
	endfunction: lane_count
endpackage: ddcf_pkg
